// ===== usb_common_pkg.sv
package usb_common_pkg;

  // ==========================================================================
  // Bus shape and register offsets
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;

  localparam logic [7:0] OFS_USB_CONTROL_A  = 8'h00;
  localparam logic [7:0] OFS_SYNC_BUSY      = 8'h02;
  localparam logic [7:0] OFS_MEM_PRIORITY   = 8'h03;
  localparam logic [7:0] OFS_LINK_STATE     = 8'h0D;

  // ==========================================================================
  // Field positions
  localparam int unsigned CA_SOFT_RESET_BIT = 0;
  localparam int unsigned CA_ENABLE_BIT     = 1;
  localparam int unsigned CA_STANDBY_BIT    = 2;
  localparam int unsigned CA_MODE_BIT       = 7;
  localparam int unsigned SB_SOFT_RESET_BIT = 0;
  localparam int unsigned SB_ENABLE_BIT     = 1;
  localparam int unsigned PRI_CONFIG_LSB    = 0;
  localparam int unsigned PRI_DATA_LSB      = 2;
  localparam int unsigned LINK_STATE_W      = 7;

  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0] CTRL_A_RESET      = 8'h00;
  localparam logic [7:0] PRIORITY_RESET    = 8'h00;
  localparam logic [6:0] LINK_STATE_RESET  = 7'h01;
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned SYNC_TIME_NS     = 80;
  localparam int unsigned SYNC_CYCLES      = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_CNT_W       = 3;

  // ==========================================================================
  // Link state codes, one-hot
  typedef enum logic [6:0] {
    LINK_OFF       = 7'h01,
    LINK_ON        = 7'h02,
    LINK_SUSPEND   = 7'h04,
    LINK_SLEEP     = 7'h08,
    LINK_DN_RESUME = 7'h10,
    LINK_UP_RESUME = 7'h20,
    LINK_BUS_RESET = 7'h40
  } link_state_code_t;

  // ==========================================================================
  // Host pipe descriptor bank 1 layout in RAM
  localparam logic [7:0] DESC_BANK1_OFS    = 8'h10;
  localparam logic [7:0] DESC_ADDR_OFS     = 8'h00;
  localparam logic [7:0] DESC_PKT_SIZE_OFS = 8'h04;

  typedef struct packed {
    logic        auto_zero_length;
    logic [2:0]  size_code;
    logic [13:0] multi_packet_size;
    logic [13:0] byte_count;
  } packet_size_word_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic       mode_host;
    logic       standby_run;
    logic       enable_active;
    logic       soft_reset;
    logic [1:0] data_priority;
    logic [1:0] config_priority;
  } ctrl_out_t;

  typedef enum logic [1:0] {
    SYNC_IDLE  = 2'b00,
    SYNC_EN    = 2'b01,
    SYNC_RESET = 2'b10
  } sync_state_t;

endpackage

// ===== usb_common_control_regs.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Control bit 7 picks device operation when zero, host operation when one.
// - Standby-run bit 2 keeps USB clock in standby; changeable only while disabled.
// - Enable-protected bits take writes only while the controller is disabled.
// - Enable bit 1 reads back at once and raises busy until applied.
// - Writing one to bit 0 resets all registers and disables; zero does nothing. The link state register at 0x0D is not reset; it keeps sampling.
// - A write setting soft reset discards every other change it carries.
// - Soft reset reads one while running; it and its busy clear together.
// - Busy bit 1 at 0x02 follows the enable synchronization.
// - Busy bit 0 at 0x02 follows the soft reset synchronization.
// - Reserved bits read zero; software writes zero to them.
// - Bits 3:2 of the priority register steer data access priority.
// - Bits 1:0 of the priority register steer configuration access priority.
// - Read-only state register at 0x0D shows seven-bit link state; writes ignored.
// - Byte, halfword and word accesses each reach their own lanes.
// - Write-protected registers ignore writes while the access guard protects them.
// - Bank 1 descriptor sits 0x10 after bank 0: address, then size word.
// - Enable reads zero when disabled or disabling, one when enabled or enabling.
// - Link state uses one-hot codes 0x01 to 0x40; others reserved.
module usb_common_control_regs
  import usb_common_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_resetn,
  // Register port
  input  wire usb_common_pkg::reg_req_t  i_req,
  output logic [usb_common_pkg::DATA_W-1:0] o_rdata,
  // Protection and engine status
  input  wire logic                      i_guard_protect,
  input  wire logic [6:0]                i_link_state,
  // Controls toward the controller core
  output usb_common_pkg::ctrl_out_t      o_ctrl
);

  // ==========================================================================
  // Registers
  logic              mode_host_ff;
  logic              standby_run_ff;
  logic              enable_ff;
  logic              enable_active_ff;
  logic [1:0]        data_priority_ff;
  logic [1:0]        config_priority_ff;
  logic [6:0]        link_state_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [SYNC_CNT_W-1:0] sync_cnt_ff;
  sync_state_t       sync_state_ff;
  logic              soft_reset_ff;

  logic              nxt_mode_host;
  logic              nxt_standby_run;
  logic              nxt_enable;
  logic              nxt_enable_active;
  logic [1:0]        nxt_data_priority;
  logic [1:0]        nxt_config_priority;
  logic [DATA_W-1:0] nxt_rdata;
  logic [SYNC_CNT_W-1:0] nxt_sync_cnt;
  sync_state_t       nxt_sync_state;
  logic              nxt_soft_reset;

  // ==========================================================================
  // Address decode
  localparam logic [5:0] CTRL_WORD  = OFS_USB_CONTROL_A[7:2];
  localparam logic [5:0] STATE_WORD = OFS_LINK_STATE[7:2];
  localparam int unsigned CTRL_LANE = int'(OFS_USB_CONTROL_A[1:0]);
  localparam int unsigned SYNC_LANE = int'(OFS_SYNC_BUSY[1:0]);
  localparam int unsigned PRI_LANE  = int'(OFS_MEM_PRIORITY[1:0]);
  localparam int unsigned LINK_LANE = int'(OFS_LINK_STATE[1:0]);
  localparam logic [SYNC_CNT_W-1:0] SYNC_LAST = SYNC_CNT_W'(SYNC_CYCLES - 1);

  wire ctrl_word_hit  = (i_req.addr[7:2] == CTRL_WORD);
  wire state_word_hit = (i_req.addr[7:2] == STATE_WORD);

  wire [7:0] ctrl_wbyte = i_req.wdata[CTRL_LANE*8 +: 8];
  wire [7:0] pri_wbyte  = i_req.wdata[PRI_LANE*8 +: 8];

  wire in_soft_reset = (sync_state_ff == SYNC_RESET);
  wire sync_done     = (sync_cnt_ff == SYNC_LAST);

  // The controller counts as disabled only when neither the software view nor
  // the applied enable is set, so a pending enable already locks the bits.
  wire is_disabled = !enable_ff && !enable_active_ff;

  // Write-protected registers stay frozen while the guard is active.
  // guard blocks writes
  wire wr_open = i_req.wr && !i_guard_protect && !in_soft_reset;

  wire ctrl_wr = wr_open && ctrl_word_hit && i_req.be[CTRL_LANE];
  wire pri_wr  = wr_open && ctrl_word_hit && i_req.be[PRI_LANE];

  wire soft_reset_req = ctrl_wr && ctrl_wbyte[CA_SOFT_RESET_BIT];

  wire ctrl_apply = ctrl_wr && !soft_reset_req;
  wire pri_apply  = pri_wr && !soft_reset_req;

  wire enable_write = ctrl_apply;

  wire standby_write = ctrl_apply && is_disabled;

  // ==========================================================================
  // Read data assembly
  wire [7:0] ctrl_rbyte;
  wire [7:0] sync_rbyte;
  wire [7:0] pri_rbyte;
  wire [7:0] link_rbyte;
  wire [DATA_W-1:0] ctrl_word_rd;
  wire [DATA_W-1:0] state_word_rd;
  wire [DATA_W-1:0] sel_word_rd;
  wire [DATA_W-1:0] lane_mask;

  assign ctrl_rbyte = {mode_host_ff, 4'h0, standby_run_ff, enable_ff, in_soft_reset};

  assign sync_rbyte = {6'h00, (sync_state_ff == SYNC_EN), in_soft_reset};

  assign pri_rbyte  = {4'h0, data_priority_ff, config_priority_ff};

  assign link_rbyte = {1'b0, link_state_ff};

  assign ctrl_word_rd = {pri_rbyte, sync_rbyte, 8'h00, ctrl_rbyte};
  assign state_word_rd = {16'h0000, link_rbyte, 8'h00};

  // Unmapped words answer zero.
  assign sel_word_rd = ctrl_word_hit  ? ctrl_word_rd  :
                       state_word_hit ? state_word_rd :
                       32'h0000_0000;

  // lanes outside the access read zero
  genvar lane;
  generate
    for (lane = 0; lane < BE_W; lane = lane + 1) begin : g_lane
      assign lane_mask[lane*8 +: 8] = i_req.be[lane] ? 8'hFF : 8'h00;
    end
  endgenerate

  assign nxt_rdata = i_req.rd ? (sel_word_rd & lane_mask) : 32'h0000_0000;

  // ==========================================================================
  // Control field next values
  always_comb begin
    nxt_mode_host       = mode_host_ff;
    nxt_standby_run     = standby_run_ff;
    nxt_enable          = enable_ff;
    nxt_data_priority   = data_priority_ff;
    nxt_config_priority = config_priority_ff;
    if (soft_reset_req) begin
      nxt_mode_host       = CTRL_A_RESET[CA_MODE_BIT];
      nxt_standby_run     = CTRL_A_RESET[CA_STANDBY_BIT];
      nxt_enable          = CTRL_A_RESET[CA_ENABLE_BIT];
      nxt_data_priority   = PRIORITY_RESET[PRI_DATA_LSB +: 2];
      nxt_config_priority = PRIORITY_RESET[PRI_CONFIG_LSB +: 2];
    end else begin
      if (ctrl_apply) begin
        nxt_mode_host = ctrl_wbyte[CA_MODE_BIT];
        nxt_enable    = ctrl_wbyte[CA_ENABLE_BIT];
      end
      if (standby_write) begin
        nxt_standby_run = ctrl_wbyte[CA_STANDBY_BIT];
      end
      if (pri_apply) begin
        nxt_data_priority   = pri_wbyte[PRI_DATA_LSB +: 2];
        nxt_config_priority = pri_wbyte[PRI_CONFIG_LSB +: 2];
      end
    end
  end

  // ==========================================================================
  // Synchronization sequencer
  // The core sees enable only after a fixed crossing delay; soft reset reaches it the next cycle and holds for that delay.
  // A new enable write while one is pending restarts the wait, so the busy
  // flag never drops before the latest value has arrived.
  always_comb begin
    nxt_sync_state    = sync_state_ff;
    nxt_sync_cnt      = sync_cnt_ff;
    nxt_enable_active = enable_active_ff;
    unique case (sync_state_ff)
      SYNC_IDLE: begin
        nxt_sync_cnt = '0;
        if (soft_reset_req) begin
          nxt_sync_state    = SYNC_RESET;
          nxt_enable_active = 1'b0;
        end else if (enable_write) begin
          nxt_sync_state = SYNC_EN;
        end
      end
      SYNC_EN: begin
        if (soft_reset_req) begin
          nxt_sync_state    = SYNC_RESET;
          nxt_sync_cnt      = '0;
          nxt_enable_active = 1'b0;
        end else if (enable_write) begin
          nxt_sync_cnt = '0;
        end else if (sync_done) begin
          nxt_sync_state    = SYNC_IDLE;
          nxt_enable_active = enable_ff;
          nxt_sync_cnt      = '0;
        end else begin
          nxt_sync_cnt = sync_cnt_ff + 1'b1;
        end
      end
      SYNC_RESET: begin
        nxt_enable_active = 1'b0;
        if (sync_done) begin
          nxt_sync_state = SYNC_IDLE;
          nxt_sync_cnt   = '0;
        end else begin
          nxt_sync_cnt = sync_cnt_ff + 1'b1;
        end
      end
      default: begin
        nxt_sync_state = SYNC_IDLE;
        nxt_sync_cnt   = '0;
      end
    endcase
  end

  // The reset level toward the core is kept in its own flop so the output
  // carries no decode logic.
  assign nxt_soft_reset = (nxt_sync_state == SYNC_RESET);

  // ==========================================================================
  // State registers
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      mode_host_ff <= CTRL_A_RESET[CA_MODE_BIT];
    end else begin
      mode_host_ff <= nxt_mode_host;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      standby_run_ff <= CTRL_A_RESET[CA_STANDBY_BIT];
    end else begin
      standby_run_ff <= nxt_standby_run;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      enable_ff <= CTRL_A_RESET[CA_ENABLE_BIT];
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      enable_active_ff <= 1'b0;
    end else begin
      enable_active_ff <= nxt_enable_active;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      data_priority_ff <= PRIORITY_RESET[PRI_DATA_LSB +: 2];
    end else begin
      data_priority_ff <= nxt_data_priority;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      config_priority_ff <= PRIORITY_RESET[PRI_CONFIG_LSB +: 2];
    end else begin
      config_priority_ff <= nxt_config_priority;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sync_state_ff <= SYNC_IDLE;
    end else begin
      sync_state_ff <= nxt_sync_state;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sync_cnt_ff <= '0;
    end else begin
      sync_cnt_ff <= nxt_sync_cnt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= nxt_soft_reset;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      link_state_ff <= LINK_STATE_RESET;
    end else begin
      link_state_ff <= i_link_state;
    end
  end

  // Read data stands for exactly one cycle after the read strobe.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_rdata = rdata_ff;

  assign o_ctrl = '{
    mode_host:       mode_host_ff,
    standby_run:     standby_run_ff,
    enable_active:   enable_active_ff,
    soft_reset:      soft_reset_ff,
    data_priority:   data_priority_ff,
    config_priority: config_priority_ff
  };

endmodule

`default_nettype wire

// ===== usb_common_control_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module usb_common_control_regs_monitor
  import usb_common_pkg::*;
(
  // Clock, reset and bus
  input wire logic                          i_mclk,
  input wire logic                          i_resetn,
  input wire usb_common_pkg::reg_req_t      i_req,
  input wire logic [usb_common_pkg::DATA_W-1:0] o_rdata,
  input wire logic                          i_guard_protect,
  input wire logic [6:0]                    i_link_state,
  input wire usb_common_pkg::ctrl_out_t     o_ctrl
);
  import usb_common_pkg::*;
  // A control write that the block must accept.
  wire logic ok_wr = i_req.wr && (i_req.addr[7:2] == 6'h00) && !i_guard_protect
                     && !o_ctrl.soft_reset;
  wire logic srst_wr = ok_wr && i_req.be[0] && i_req.wdata[0];
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_en_set;
    ok_wr && i_req.be[0] && i_req.wdata[1] && !i_req.wdata[0] && !o_ctrl.enable_active;
  endsequence
  sequence s_quiet;
    !i_req.wr [*4];
  endsequence
  property p_rdata_idle;
    !$past(i_req.rd) |-> o_rdata == 32'h0;
  endproperty
  property p_srst_clear;
    srst_wr |=> o_ctrl.soft_reset && !o_ctrl.enable_active && !o_ctrl.mode_host
      && o_ctrl.data_priority == 2'h0 && o_ctrl.config_priority == 2'h0;
  endproperty
  property p_srst_len;
    $rose(o_ctrl.soft_reset) |-> o_ctrl.soft_reset [*4] ##1 !o_ctrl.soft_reset;
  endproperty
  property p_en_sync;
    s_en_set ##1 s_quiet |=> o_ctrl.enable_active;
  endproperty
  property p_mode;
    ok_wr && i_req.be[0] && !i_req.wdata[0] |=> o_ctrl.mode_host == $past(i_req.wdata[7]);
  endproperty
  property p_prio;
    ok_wr && i_req.be[3] && !(i_req.be[0] && i_req.wdata[0])
      |=> {o_ctrl.data_priority, o_ctrl.config_priority} == $past(i_req.wdata[27:24]);
  endproperty
  property p_guard;
    i_req.wr && i_req.addr == 8'h00 && i_guard_protect
      |=> $stable(o_ctrl.mode_host) && $stable(o_ctrl.data_priority);
  endproperty
  property p_standby_lock;
    i_req.wr && i_req.addr == 8'h00 && o_ctrl.enable_active && !i_req.wdata[0]
      |=> $stable(o_ctrl.standby_run);
  endproperty
  property p_word0_reserved;
    i_req.rd && i_req.addr == 8'h00 && i_req.be == 4'hF
      |=> o_rdata[6:3] == 4'h0 && o_rdata[15:8] == 8'h00 && o_rdata[31:28] == 4'h0;
  endproperty
  property p_en_readback;
    ok_wr && i_req.be[0] && !i_req.wdata[0] ##1 !i_req.wr
      ##1 i_req.rd && i_req.addr == 8'h00 && i_req.be[0]
      |=> o_rdata[1] == $past(i_req.wdata[1], 3);
  endproperty
  property p_link;
    i_req.rd && i_req.addr[7:2] == 6'h03 && i_req.be[1]
      |=> o_rdata[15:8] == {1'b0, $past(i_link_state, 2)};
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset kept fields");
  a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
  a_en_sync: assert property (p_en_sync) else $error("enable not applied");
  a_mode: assert property (p_mode) else $error("mode not written");
  a_prio: assert property (p_prio) else $error("priority not written");
  a_guard: assert property (p_guard) else $error("guarded write applied");
  a_standby_lock: assert property (p_standby_lock) else $error("standby changed");
  a_word0_reserved: assert property (p_word0_reserved) else $error("reserved set");
  a_en_readback: assert property (p_en_readback) else $error("enable readback");
  a_link: assert property (p_link) else $error("link state read wrong");
endmodule
bind usb_common_control_regs usb_common_control_regs_monitor u_mon (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_req(i_req), .o_rdata(o_rdata),
  .i_guard_protect(i_guard_protect), .i_link_state(i_link_state), .o_ctrl(o_ctrl));
`default_nettype wire

// ===== test_usb_common_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_usb_common_control_regs;
  import usb_common_pkg::*;
  logic        i_mclk;
  logic        i_resetn;
  reg_req_t    req;
  logic [31:0] rdata;
  logic        guard;
  logic [6:0]  link;
  ctrl_out_t   ctrl;
  int          failures;
  int          n_checks;
  usb_common_control_regs DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_req(req),
    .o_rdata(rdata), .i_guard_protect(guard), .i_link_state(link), .o_ctrl(ctrl));
  // ==========================================================================
  // Bus tasks and comparison
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    req.addr <= a;
    req.be <= be;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge i_mclk);
    req.wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [3:0] be, output logic [31:0] d);
    req.addr <= a;
    req.be <= be;
    req.rd <= 1'b1;
    @(posedge i_mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
    @(posedge i_mclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] e);
    logic [31:0] d;
    bus_rd(a, be, d);
    chk("read", d, e);
  endtask
  task automatic ctl(input logic [7:0] e);
    #1 chk("ctrl", 32'(ctrl), 32'(e));
  endtask
  task automatic wait_idle;
    logic [31:0] d;
    d = 32'h0003_0000;
    for (int i = 0; i < 12 && d[17:16] != 2'h0; i++) bus_rd(8'h00, 4'hF, d);
    chk("sync_busy", 32'(d[17:16]), 32'h0);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_link;
    for (int i = 0; i < 7; i++) begin
      link <= 7'h01 << i;
      bus_wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
      rchk(8'h0C, 4'hF, {16'h0, 1'b0, 7'(7'h01 << i), 8'h0});
    end
  endtask
  task automatic t_guard;
    guard <= 1'b1;
    bus_wr(8'h00, 4'hF, 32'h0F00_0084);
    ctl(8'h00);
    guard <= 1'b0;
  endtask
  task automatic t_prio;
    bus_wr(8'h03, 4'h8, 32'h0E00_0000);
    ctl(8'h0E);
    rchk(8'h03, 4'h8, 32'h0E00_0000);
    rchk(8'h02, 4'hC, 32'h0E00_0000);
    rchk(8'h00, 4'h1, 32'h0);
  endtask
  task automatic t_enable;
    bus_wr(8'h00, 4'h1, 32'h0000_0082);
    ctl(8'h8E);
    rchk(8'h00, 4'hF, 32'h0E02_0082);
    wait_idle;
    ctl(8'hAE);
    rchk(8'h00, 4'hF, 32'h0E00_0082);
  endtask
  task automatic t_standby;
    bus_wr(8'h00, 4'h1, 32'h0000_0086);
    ctl(8'hAE);
    wait_idle;
    bus_wr(8'h00, 4'h1, 32'h0000_0080);
    wait_idle;
    ctl(8'h8E);
    bus_wr(8'h00, 4'h1, 32'h0000_0084);
    ctl(8'hCE);
  endtask
  task automatic t_software_reset_bit;
    wait_idle;
    bus_wr(8'h00, 4'h9, 32'h0300_0083);
    ctl(8'h10);
    rchk(8'h00, 4'hF, 32'h0001_0001);
    bus_wr(8'h00, 4'h1, 32'h0000_0080);
    wait_idle;
    ctl(8'h00);
    rchk(8'h00, 4'hF, 32'h0);
  endtask
  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    failures = 0;
    n_checks = 0;
    req = '0;
    guard = 1'b0;
    link = 7'h01;
    i_resetn = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rchk(8'h00, 4'hF, 32'h0);
    rchk(8'h0C, 4'hF, 32'h0000_0100);
    t_link;
    t_guard;
    t_prio;
    t_enable;
    t_standby;
    t_software_reset_bit;
    report_and_stop;
  end
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
